//--- hw/ppsh_pin_select.sv
// Purpose: Boot-time function select of four shared pins and bus hold handshake
// Assumes: Memory controller reports access in progress; pin pads resolve enables
// Notes:   Selection latched on the first enabled edge after reset release
`timescale 1ns/1ps

module ppsh_pin_select (
  input  wire logic                          clk_sys,
  input  wire logic                          rst,
  input  wire logic                          clk_en,
  input  wire logic                          boot_select_pin,
  input  wire logic [ppsh_pkg::NUM_PINS-1:0] shared_pin_in,
  output logic      [ppsh_pkg::NUM_PINS-1:0] shared_pin_out,
  output logic      [ppsh_pkg::NUM_PINS-1:0] shared_pin_oe,
  input  wire logic [ppsh_pkg::NUM_PINS-1:0] gpio_out,
  input  wire logic [ppsh_pkg::NUM_PINS-1:0] gpio_dir_out,
  output logic      [ppsh_pkg::NUM_PINS-1:0] gpio_in,
  input  wire logic                          mem_busy,
  input  wire logic                          sdram_cke_req,
  input  wire logic                          soe3_req,
  output logic                               mem_mode,
  output logic                               mem_bus_release,
  output logic                               bus_hold_active
);
  logic                          in_reset;
  logic                          boot_sample;
  logic                          mode_locked;
  logic [2:0]                    boot_stage;
  logic                          boot_agree;
  logic                          hold_req_sync;
  logic [ppsh_pkg::NUM_PINS-1:0] pin_sync;
  ppsh_pkg::ppsh_state_type      state;
  ppsh_pkg::ppsh_state_type      next_state;

  // ==========================================================================
  // Pin input synchronisers
  genvar gi;
  generate
    for (gi = 0; gi < ppsh_pkg::NUM_PINS; gi++) begin : g_sync
      ppsh_sync #(
        .RESET_VALUE (1'b1)
      ) u_sync (
        .clk_sys  (clk_sys),
        .rst      (rst),
        .clk_en   (clk_en),
        .async_in (shared_pin_in[gi]),
        .sync_out (pin_sync[gi])
      );
    end
  endgenerate

  // Hold request only counts in memory mode
  assign hold_req_sync = mode_locked ? (pin_sync[ppsh_pkg::PIN_HOLD] == ppsh_pkg::HOLD_ACTIVE_LEVEL) : 1'b0;

  // ==========================================================================
  // Boot select capture and lock
  // Strap chain runs through reset so the level is seen while reset is held
  always_ff @(posedge clk_sys) begin
    if (clk_en) begin
      boot_stage <= {boot_stage[1:0], boot_select_pin};
    end
  end

  // A strap change counts once stages two and three agree
  assign boot_agree = (boot_stage[1] == boot_stage[2]);

  // Strap taken on reset cycles where stages two and three agree, reset flag cleared on first enabled edge
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      in_reset    <= 1'b1;
      if (boot_agree) begin
        boot_sample <= boot_stage[2];
      end
    end else if (clk_en) begin
      in_reset    <= 1'b0;
    end
  end

  // Lock on the first enabled edge after release
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      mode_locked <= ppsh_pkg::MODE_GPIO;
    end else if (clk_en && in_reset) begin
      mode_locked <= boot_sample;
    end
  end

  // ==========================================================================
  // Hold handshake next state
  always_comb begin
    next_state = state;
    case (state)
      ppsh_pkg::PPSH_RUN: begin
        if (hold_req_sync) begin
          next_state = ppsh_pkg::PPSH_DRAIN;
        end
      end
      ppsh_pkg::PPSH_DRAIN: begin
        if (!hold_req_sync) begin
          next_state = ppsh_pkg::PPSH_RUN;
        end else if (!mem_busy) begin
          next_state = ppsh_pkg::PPSH_HELD;
        end
      end
      ppsh_pkg::PPSH_HELD: begin
        if (!hold_req_sync) begin
          next_state = ppsh_pkg::PPSH_RESUME;
        end
      end
      ppsh_pkg::PPSH_RESUME: begin
        next_state = ppsh_pkg::PPSH_RUN;
      end
      default: begin
        next_state = ppsh_pkg::PPSH_RUN;
      end
    endcase
  end

  // Bus release is raised in DRAIN exit, before acknowledge
  wire next_release = (next_state == ppsh_pkg::PPSH_HELD);
  wire next_ack     = (state == ppsh_pkg::PPSH_HELD) && mem_bus_release;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state           <= ppsh_pkg::PPSH_RUN;
      mem_bus_release <= 1'b0;
      bus_hold_active <= 1'b0;
    end else if (clk_en) begin
      state           <= next_state;
      mem_bus_release <= next_release;
      bus_hold_active <= next_ack && next_release;
    end
  end

  // ==========================================================================
  // Pin drive selection
  wire [ppsh_pkg::NUM_PINS-1:0] mem_out;
  wire [ppsh_pkg::NUM_PINS-1:0] mem_oe;
  assign mem_out[ppsh_pkg::PIN_CKE]   = sdram_cke_req;
  assign mem_out[ppsh_pkg::PIN_SOE3]  = soe3_req;
  assign mem_out[ppsh_pkg::PIN_HOLD]  = 1'b1;
  assign mem_out[ppsh_pkg::PIN_HOLDA] = (next_ack && next_release) ? 1'b0 : ppsh_pkg::HOLDA_IDLE_VALUE;
  assign mem_oe[ppsh_pkg::PIN_CKE]    = !next_release;
  assign mem_oe[ppsh_pkg::PIN_SOE3]   = !next_release;
  assign mem_oe[ppsh_pkg::PIN_HOLD]   = 1'b0;
  assign mem_oe[ppsh_pkg::PIN_HOLDA]  = 1'b1;

  wire [ppsh_pkg::NUM_PINS-1:0] next_out = mode_locked ? mem_out : gpio_out;
  wire [ppsh_pkg::NUM_PINS-1:0] next_oe  = mode_locked ? mem_oe : gpio_dir_out;

  // Outputs float in reset and during the lock cycle
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      shared_pin_out <= {ppsh_pkg::NUM_PINS{1'b1}};
      shared_pin_oe  <= '0;
      gpio_in        <= '0;
      mem_mode       <= ppsh_pkg::MODE_GPIO;
    end else if (clk_en) begin
      shared_pin_out <= next_out;
      shared_pin_oe  <= in_reset ? '0 : next_oe;
      gpio_in        <= pin_sync;
      mem_mode       <= mode_locked;
    end
  end

  // ==========================================================================
  // Checks
  mode_stable_a : assert property (@(posedge clk_sys) disable iff (rst)
    (!in_reset && !$past(in_reset) && $past(!rst)) |-> $stable(mode_locked))
    else $error("function select changed after lock");

  mode_from_boot_a : assert property (@(posedge clk_sys) disable iff (rst)
    ($past(in_reset) && $past(clk_en) && $past(!rst)) |-> (mode_locked == $past(boot_sample)))
    else $error("function select not taken from boot pin");

  gpio_input_a : assert property (@(posedge clk_sys) disable iff (rst)
    ($past(rst) || $past(in_reset)) |-> (shared_pin_oe == '0))
    else $error("pins driven at reset release");

  cke_high_a : assert property (@(posedge clk_sys) disable iff (rst)
    (mem_mode && shared_pin_oe[ppsh_pkg::PIN_CKE] && $past(sdram_cke_req) && $past(clk_en))
      |-> shared_pin_out[ppsh_pkg::PIN_CKE])
    else $error("clock enable not driven high");

  soe3_idle_a : assert property (@(posedge clk_sys) disable iff (rst)
    (mem_mode && shared_pin_oe[ppsh_pkg::PIN_SOE3] && $past(soe3_req) && $past(clk_en))
      |-> shared_pin_out[ppsh_pkg::PIN_SOE3])
    else $error("space-3 output enable not driven high");

  holda_idle_a : assert property (@(posedge clk_sys) disable iff (rst)
    (mem_mode && !bus_hold_active && shared_pin_oe[ppsh_pkg::PIN_HOLDA]) |-> shared_pin_out[ppsh_pkg::PIN_HOLDA])
    else $error("acknowledge not idle high");

  ack_in_hold_a : assert property (@(posedge clk_sys) disable iff (rst)
    bus_hold_active |-> (mem_bus_release && state == ppsh_pkg::PPSH_HELD))
    else $error("acknowledge outside hold state");

  ack_after_float_a : assert property (@(posedge clk_sys) disable iff (rst)
    $rose(bus_hold_active) |-> $past(mem_bus_release))
    else $error("acknowledge before bus float");

  drain_wait_a : assert property (@(posedge clk_sys) disable iff (rst)
    (state == ppsh_pkg::PPSH_DRAIN && mem_busy && clk_en) |=> (state != ppsh_pkg::PPSH_HELD))
    else $error("hold granted during access");

  gpio_no_hold_a : assert property (@(posedge clk_sys) disable iff (rst)
    !mode_locked |-> (state == ppsh_pkg::PPSH_RUN))
    else $error("hold handshake active in general I/O mode");

  float_in_hold_a : assert property (@(posedge clk_sys) disable iff (rst)
    (mem_mode && mem_bus_release) |->
      (!shared_pin_oe[ppsh_pkg::PIN_CKE] && !shared_pin_oe[ppsh_pkg::PIN_SOE3]))
    else $error("memory pins driven during bus release");

  ack_pin_low_a : assert property (@(posedge clk_sys) disable iff (rst)
    (mem_mode && shared_pin_oe[ppsh_pkg::PIN_HOLDA] && !shared_pin_out[ppsh_pkg::PIN_HOLDA])
      |-> bus_hold_active)
    else $error("acknowledge pin low outside hold");
endmodule

//--- hw/ppsh_pkg.sv
// Purpose: Constants for the shared parallel-port pin select and bus hold logic
// Assumes: One system clock, synchronous active-high reset
// Notes:   Pin order is twelve, thirteen, fourteen, fifteen on index 0..3
package ppsh_pkg;
  // ==========================================================================
  // Pin indices and counts
  localparam int unsigned NUM_PINS      = 4;
  localparam int unsigned PIN_CKE       = 0;
  localparam int unsigned PIN_SOE3      = 1;
  localparam int unsigned PIN_HOLD      = 2;
  localparam int unsigned PIN_HOLDA     = 3;
  // ==========================================================================
  // Reset and idle values
  localparam logic CKE_RUN_VALUE        = 1'b1;
  localparam logic SOE3_IDLE_VALUE      = 1'b1;
  localparam logic HOLDA_IDLE_VALUE     = 1'b1;
  localparam logic HOLD_ACTIVE_LEVEL    = 1'b0;
  localparam logic MODE_GPIO            = 1'b0;
  localparam logic MODE_MEM             = 1'b1;
  localparam int unsigned SYNC_STAGES   = 3;
  // ==========================================================================
  // Hold handshake states
  typedef enum logic [1:0] {
    PPSH_RUN     = 2'b00,
    PPSH_DRAIN   = 2'b01,
    PPSH_HELD    = 2'b10,
    PPSH_RESUME  = 2'b11
  } ppsh_state_type;
endpackage

//--- hw/ppsh_sync.sv
// Purpose: Three-stage synchroniser with agreement filter for a pin input
// Assumes: Input is asynchronous to clk_sys
// Notes:   Output changes only once stages two and three agree
`timescale 1ns/1ps
module ppsh_sync #(
  parameter logic RESET_VALUE = 1'b1
) (
  input  wire logic clk_sys,
  input  wire logic rst,
  input  wire logic clk_en,
  input  wire logic async_in,
  output logic      sync_out
);
  logic [2:0] stage;
  wire        agree = (stage[1] == stage[2]);

  // ==========================================================================
  // Shift chain and filtered output
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      stage    <= {3{RESET_VALUE}};
      sync_out <= RESET_VALUE;
    end else if (clk_en) begin
      stage    <= {stage[1:0], async_in};
      if (agree) begin
        sync_out <= stage[2];
      end
    end
  end
endmodule

//--- dv/ppsh_host_model.sv
// Purpose: External host that asks for the memory bus
// Assumes: Hold request and acknowledge are active low at the pads
// Notes:   Keeps the bus for hold_len cycles, then lets it go
`timescale 1ns/1ps
module ppsh_host_model (
  input  wire logic       clk_sys,
  input  wire logic       start,
  input  wire logic [7:0] hold_len,
  input  wire logic       ack_n,
  output logic            hold_n,
  output logic            done
);
  logic [1:0] st;
  logic [7:0] cnt;
  // ==========================================================================
  // Request, wait for acknowledge, hold, release, wait for acknowledge drop
  initial begin
    hold_n = 1'b1;
    done = 1'b0;
    st = 2'd0;
    cnt = 8'h00;
  end
  always @(posedge clk_sys) begin
    done <= 1'b0;
    case (st)
      2'd0: if (start) begin
        hold_n <= 1'b0;
        st <= 2'd1;
      end
      2'd1: if (ack_n == 1'b0) begin
        cnt <= hold_len;
        st <= 2'd2;
      end
      2'd2: if (cnt <= 8'h01) begin
        hold_n <= 1'b1;
        st <= 2'd3;
      end else cnt <= cnt - 8'h01;
      default: if (ack_n == 1'b1) begin
        done <= 1'b1;
        st <= 2'd0;
      end
    endcase
  end
endmodule

//--- dv/testbench.sv
// Purpose: Self-checking bench for the shared pin select and bus hold
// Assumes: Pads resolved here from the design enables and far-side levels
// Notes:   Fixed seed; mode checked in both boot settings
`timescale 1ns/1ps
module testbench;
  logic       clk_sys = 1'b0, rst = 1'b1, boot = 1'b0, busy = 1'b0, hreq = 1'b0;
  logic [3:0] ext = 4'h0, g_out = 4'h0, pout, poe, g_in, pad;
  logic [3:0] dir = 4'h0, s_in, s_oe, s_out;
  logic       en = 1'b1, cke = 1'b1, soe = 1'b1;
  logic       mmode, rel, hact, hold_n, hdone;
  logic [7:0] hlen = 8'h01;
  int         n_fail = 0, n_tests = 0, cyc = 0, w, seen;
  // ==========================================================================
  // Clock, pads, design and host
  always #12.5 clk_sys = ~clk_sys;
  assign pad = (poe & pout) | (~poe & {ext[3], mmode ? hold_n : ext[2], ext[1:0]});
  ppsh_pin_select dut (.clk_sys(clk_sys), .rst(rst), .clk_en(en), .boot_select_pin(boot),
    .shared_pin_in(pad), .shared_pin_out(pout), .shared_pin_oe(poe), .gpio_out(g_out),
    .gpio_dir_out(dir), .gpio_in(g_in), .mem_busy(busy), .sdram_cke_req(cke),
    .soe3_req(soe), .mem_mode(mmode), .mem_bus_release(rel), .bus_hold_active(hact));
  ppsh_host_model host (.clk_sys(clk_sys), .start(hreq), .hold_len(hlen), .ack_n(pad[3]),
    .hold_n(hold_n), .done(hdone));
  // ==========================================================================
  // Checking and closing
  task automatic chk(input string nm, input logic [3:0] got, input logic [3:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic tally_and_finish();
    if (n_fail == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  function automatic logic [3:0] exp_oe(input logic b);
    return b ? 4'b1011 : 4'b0000;
  endfunction
  // Pad level seen back: driven lines show GPIO data, the rest the far side
  function automatic logic [3:0] exp_gin(input logic [3:0] e, input logic [3:0] d, input logic [3:0] r);
    return (r & d) | (~r & e);
  endfunction
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      tally_and_finish();
    end
  end
  // ==========================================================================
  // Reset with a boot level, flipped at release
  task automatic do_reset(input logic b);
    @(posedge clk_sys);
    rst <= 1'b1;
    boot <= b;
    ext <= {4{b}};
    dir <= 4'h0;
    cke <= 1'b1;
    soe <= 1'b1;
    repeat (20) @(posedge clk_sys);
    #1 chk("oe_rst", poe, 4'h0);
    @(posedge clk_sys);
    rst <= 1'b0;
    boot <= ~b;
    repeat (3) @(posedge clk_sys);
    #1 chk("mode", {3'h0, mmode}, {3'h0, b});
    chk("oe", poe, exp_oe(b));
    chk("drive", pout & poe, exp_oe(b));
  endtask
  // ==========================================================================
  // Main sequence
  initial begin
    void'($urandom(50064));
    do_reset(1'b0);
    for (int k = 0; k < 8; k++) begin
      @(posedge clk_sys);
      ext <= 4'($urandom);
      g_out <= 4'($urandom);
      dir <= (k < 2) ? 4'h0 : 4'($urandom);
      boot <= 1'($urandom);
      repeat (7) @(posedge clk_sys);
      #1 chk("gpio_in", g_in, exp_gin(ext, g_out, dir));
      chk("gpio_oe", poe, dir);
      chk("gpio_drv", pout & poe, g_out & dir);
      chk("mode_hold", {2'h0, mmode, hact}, 4'h0);
    end
    // Clock enable low: every flop keeps its value while the pins move
    s_in = g_in;
    s_oe = poe;
    s_out = pout;
    @(posedge clk_sys);
    en <= 1'b0;
    ext <= ~ext;
    g_out <= ~g_out;
    dir <= ~dir;
    repeat (8) @(posedge clk_sys);
    #1 chk("frz_in", g_in, s_in);
    chk("frz_oe", poe, s_oe);
    chk("frz_out", pout, s_out);
    en <= 1'b1;
    repeat (7) @(posedge clk_sys);
    #1 chk("thaw_in", g_in, exp_gin(ext, g_out, dir));
    chk("thaw_oe", poe, dir);
    do_reset(1'b1);
    for (int k = 0; k < 6; k++) begin
      @(posedge clk_sys);
      busy <= 1'b1;
      hreq <= 1'b1;
      hlen <= 8'($urandom_range(1, 15));
      cke <= 1'($urandom);
      soe <= 1'($urandom);
      @(posedge clk_sys);
      hreq <= 1'b0;
      repeat ((k == 0) ? 12 : $urandom_range(0, 7)) begin
        @(posedge clk_sys);
        #1 chk("busy_hold", {3'h0, hact}, 4'h0);
      end
      @(posedge clk_sys);
      busy <= 1'b0;
      w = 0;
      seen = 0;
      while (hdone !== 1'b1 && w < 200) begin
        @(posedge clk_sys);
        #1 w++;
        if (hact === 1'b1) begin
          seen++;
          chk("held", {rel, poe[1:0], pad[3]}, 4'b1000);
        end
      end
      chk("ack_seen", {3'h0, seen > 0 && w < 200}, 4'h1);
      repeat (2) @(posedge clk_sys);
      #1 chk("resume", {hact, rel, pad[3], pout[3]}, 4'b0011);
      chk("oe_run", poe, 4'b1011);
      chk("mem_out", {2'h0, pout[1:0]}, {2'h0, soe, cke});
    end
    tally_and_finish();
  end
endmodule
